// ===== tb_external_char_input_port.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin mismatches++; \
  $display("ERROR %0t got %h want %h", $time, (a), (b)); end end
`define WAIT(c) begin n = 0; while (!(c) && n < 300) begin @(posedge pclk); n++; end \
  if (n >= 300) begin $display("ERROR %0t timeout", $time); mismatches++; complete_run(); end end
module tb_external_char_input_port;
  localparam int G6 = 20;
  localparam int G5 = 24;
  localparam int GO = 40;
  logic pclk, presetn, psel, penable, pwrite, send, slow, rogue, err, ep;
  logic [7:0] paddr, chr, dl;
  logic [31:0] pwdata, prdata, q;
  logic pready, pslverr, irq, ivs, psl, rha, rhb, inh, stb, stbc;
  logic scbo, seo, sreq, act, inact, rdy, perr, d4, d5, d6;
  int mismatches, checks, n;

  xcp_char_port #(.GAP_AN6(G6), .GAP_AN5(G5), .GAP_OCT(GO)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .data_in_line_1(dl[0]), .data_in_line_2(dl[1]), .data_in_line_3(dl[2]),
    .data_in_line_4(dl[3]), .data_in_line_5(dl[4]), .data_in_line_6(dl[5]),
    .data_in_line_7(dl[6]), .data_in_line_8(dl[7]), .input_strobe(stb),
    .input_strobe_complement(stbc), .input_verify_select(ivs), .parity_select(psl),
    .run_halt_ctrl_a(rha), .run_halt_ctrl_b(rhb), .parity_inhibit_in(inh),
    .strobe_complement_buffered_out(scbo), .strobe_echo_out(seo),
    .sample_request_out(sreq), .ext_input_active(act), .ext_input_inactive(inact),
    .input_ready_out(rdy), .parity_error_out(perr), .discrete_out_4(d4),
    .discrete_out_5(d5), .discrete_out_6(d6));
  xcp_tape_model peer (.pclk(pclk), .send(send), .slow(slow), .rogue(rogue), .chr(chr),
    .sample_request_out(sreq), .strobe_echo_out(seo), .data(dl), .input_strobe(stb),
    .input_strobe_complement(stbc));

  // ****************************************
  // bus cycle and closing
  // ****************************************
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    `WAIT(pready === 1'b1)
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    `CHK({act, inact}, 2'b01)
    `CHK({sreq, rdy, d6, d5, d4, irq}, 6'h00)
    apb(1'b0, xcp_pkg::ADDR_CTRL, 32'h0);
    `CHK(q[0], xcp_pkg::CTRL_EXT_EN_RST)
    apb(1'b0, xcp_pkg::ADDR_STATUS, 32'h0);
    `CHK(q[xcp_pkg::ST_VERIFY_BIT], 1'b0)
    apb(1'b0, 8'h3C, 32'h0);
    `CHK({err, q}, 33'h100000000)
    $display("t_reset done");
  endtask

  task automatic t_disc();
    logic [11:0] op [5] = '{xcp_pkg::OP_DISC4, xcp_pkg::OP_DISC5, xcp_pkg::OP_DISC6,
      12'h123, xcp_pkg::OP_DISC_OFF};
    logic [2:0] ex [5] = '{3'h1, 3'h2, 3'h4, 3'h4, 3'h0};
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, xcp_pkg::ADDR_OPCODE, {20'h0, op[i]});
      @(posedge pclk);
      `CHK({d6, d5, d4}, ex[i])
      apb(1'b0, xcp_pkg::ADDR_OPCODE, 32'h0);
      `CHK(q[2:0], ex[i])
    end
    $display("t_disc done");
  endtask

  task automatic t_char();
    // last character fails the odd check, so only the inhibit keeps the error away
    logic [7:0] c [5] = '{8'h01, 8'hC3, 8'h81, 8'h80, 8'hFF};
    logic [1:0] rt [5] = '{xcp_pkg::RATE_AN6, xcp_pkg::RATE_AN5, xcp_pkg::RATE_OCT,
      xcp_pkg::RATE_AN6, xcp_pkg::RATE_AN6};
    int g [5] = '{G6, G5, GO, G6, G6};
    logic [4:0] ps = 5'h13;
    logic [4:0] ih = 5'h10;
    logic [4:0] sl = 5'h02;
    longint t0;
    apb(1'b1, xcp_pkg::ADDR_INT_MASK, 32'h3);
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, xcp_pkg::ADDR_CTRL, {29'h0, rt[i], 1'b1});
      psl <= ps[i];
      inh <= ih[i];
      chr <= c[i];
      slow <= sl[i];
      ep = ih[i] ? 1'b0 : (ps[i] ? ~^c[i] : ^c[i]);
      `WAIT(sreq === 1'b1)
      `CHK({act, inact}, 2'b10)
      `CHK(rdy, 1'b0)
      send <= 1'b1;
      `WAIT(sreq === 1'b0)
      t0 = $time;
      send <= 1'b0;
      `WAIT(seo === 1'b0)
      `CHK(scbo, 1'b1)
      `CHK(rdy, 1'b1)
      `CHK(perr, ep)
      `CHK(irq, 1'b1)
      apb(1'b0, xcp_pkg::ADDR_DATA, 32'h0);
      `CHK(q[7:0], c[i])
      apb(1'b0, xcp_pkg::ADDR_STATUS, 32'h0);
      `CHK(q[xcp_pkg::ST_PERR_BIT], ep)
      apb(1'b0, xcp_pkg::ADDR_INT_STATUS, 32'h0);
      `CHK(q[2:0], {1'b0, ep, 1'b1})
      repeat (2) @(posedge pclk);
      `CHK(irq, 1'b0)
      `WAIT(sreq === 1'b1)
      `CHK($time - t0 >= g[i] * 4, 1'b1)
      `CHK({seo, scbo}, 2'b10)
    end
    $display("t_char done");
  endtask

  task automatic t_halt();
    for (int i = 0; i < 2; i++) begin
      {rha, rhb} <= (i == 0) ? 2'b10 : 2'b01;
      `WAIT(act === 1'b0)
      `CHK({inact, sreq, rdy, irq}, 4'b1000)
      // a character unlike the last captured one, so a wrong capture shows
      chr <= 8'h3C;
      rogue <= 1'b1;
      send <= 1'b1;
      `WAIT(seo === 1'b0)
      rogue <= 1'b0;
      send <= 1'b0;
      `WAIT(seo === 1'b1)
      apb(1'b0, xcp_pkg::ADDR_INT_STATUS, 32'h0);
      `CHK(q[2:0], 3'h4)
      apb(1'b0, xcp_pkg::ADDR_DATA, 32'h0);
      `CHK(q[7:0], 8'hFF)
      {rha, rhb} <= 2'b00;
      `WAIT(act === 1'b1)
    end
    ivs <= 1'b0;
    // settle through the input synchroniser
    repeat (4) @(posedge pclk);
    apb(1'b0, xcp_pkg::ADDR_STATUS, 32'h0);
    `CHK(q[xcp_pkg::ST_VERIFY_BIT], 1'b1)
    $display("t_halt done");
  endtask

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  initial begin
    {presetn, psel, penable, pwrite, send, slow, rogue, rha, rhb, inh} = 10'h000;
    {ivs, psl} = 2'b11;
    paddr = 8'h00;
    pwdata = 32'h0;
    chr = 8'h00;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_disc();
    t_char();
    t_halt();
    complete_run();
  end
endmodule

// ===== xcp_char_port.sv
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/1ps
module xcp_char_port #(
  parameter int GAP_AN6 = xcp_pkg::AN6_GAP_CYC,
  parameter int GAP_AN5 = xcp_pkg::AN5_GAP_CYC,
  parameter int GAP_OCT = xcp_pkg::OCT_GAP_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic data_in_line_1,
  input wire logic data_in_line_2,
  input wire logic data_in_line_3,
  input wire logic data_in_line_4,
  input wire logic data_in_line_5,
  input wire logic data_in_line_6,
  input wire logic data_in_line_7,
  input wire logic data_in_line_8,
  input wire logic input_strobe,
  input wire logic input_strobe_complement,
  input wire logic input_verify_select,
  input wire logic parity_select,
  input wire logic run_halt_ctrl_a,
  input wire logic run_halt_ctrl_b,
  input wire logic parity_inhibit_in,
  output logic strobe_complement_buffered_out,
  output logic strobe_echo_out,
  output logic sample_request_out,
  output logic ext_input_active,
  output logic ext_input_inactive,
  output logic input_ready_out,
  output logic parity_error_out,
  output logic discrete_out_4,
  output logic discrete_out_5,
  output logic discrete_out_6
);

  typedef struct packed {
    logic ext_en;
    logic [1:0] rate;
    logic [2:0] mask;
    logic [2:0] ist;
    logic [7:0] chr;
    logic full;
    logic sreq;
    logic perr;
    logic [2:0] disc;
    logic [xcp_pkg::GAP_W-1:0] hold;
    logic strb_d;
    logic halt_d;
    logic echo;
    logic cbuf;
    logic act;
    logic inact;
    logic rdy;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } xcp_state_t;

  xcp_state_t st;
  xcp_state_t next_st;

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [xcp_pkg::SYNC_W-1:0] pins_raw;
  logic [xcp_pkg::SYNC_W-1:0] pins_s;
  logic [7:0] data_s;
  logic strb_s;
  logic strbc_s;
  logic ivs_s;
  logic psel_s;
  logic rha_s;
  logic rhb_s;
  logic inh_s;

  assign pins_raw = {parity_inhibit_in, run_halt_ctrl_b, run_halt_ctrl_a, parity_select,
                     input_verify_select, input_strobe_complement, input_strobe,
                     data_in_line_8, data_in_line_7, data_in_line_6, data_in_line_5,
                     data_in_line_4, data_in_line_3, data_in_line_2, data_in_line_1};

  xcp_sync #(.W(xcp_pkg::SYNC_W)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din(pins_raw),
    .dout(pins_s)
  );

  assign {inh_s, rhb_s, rha_s, psel_s, ivs_s, strbc_s, strb_s} = pins_s[14:8];
  assign data_s = pins_s[7:0];

  logic par_err;

  xcp_parity #(.W(8)) u_parity (
    .data(data_s),
    .odd_sel(psel_s),
    .err(par_err)
  );

  // ****************************************
  // character handshake
  // ****************************************
  logic halted;
  logic act;
  logic rise;
  logic cap;
  logic [xcp_pkg::GAP_W-1:0] gap;
  logic [xcp_pkg::EV_W-1:0] ev;

  assign halted = rha_s | rhb_s;
  assign act = st.ext_en & ~halted;
  assign rise = strb_s & ~st.strb_d;
  assign cap = st.sreq & rise;

  always_comb begin
    case (st.rate)
      xcp_pkg::RATE_AN5: gap = xcp_pkg::GAP_W'(GAP_AN5);
      xcp_pkg::RATE_OCT: gap = xcp_pkg::GAP_W'(GAP_OCT);
      default: gap = xcp_pkg::GAP_W'(GAP_AN6);
    endcase
  end

  // ****************************************
  // apb decode
  // ****************************************
  logic setup;
  logic access;
  logic wr;
  logic rd;
  logic hit;
  logic [31:0] rdata;
  logic [2:0] clr;
  logic [31:0] status;

  assign setup = psel & ~penable;
  assign access = psel & penable & st.pready;
  assign wr = access & pwrite;
  assign rd = access & ~pwrite;
  assign clr = (rd && paddr == xcp_pkg::ADDR_INT_STATUS) ? st.prdata[2:0] : 3'h0;

  always_comb begin
    status = 32'h0;
    status[xcp_pkg::ST_ACTIVE_BIT] = st.act;
    status[xcp_pkg::ST_HALTED_BIT] = halted;
    status[xcp_pkg::ST_VERIFY_BIT] = ~ivs_s;
    status[xcp_pkg::ST_FULL_BIT] = st.full;
    status[xcp_pkg::ST_SREQ_BIT] = st.sreq;
    status[xcp_pkg::ST_PERR_BIT] = st.perr;
    status[xcp_pkg::ST_DISC_LSB +: 3] = st.disc;
  end

  always_comb begin
    hit = 1'b1;
    rdata = 32'h0;
    case (paddr)
      xcp_pkg::ADDR_CTRL: rdata = {29'h0, st.rate, st.ext_en};
      xcp_pkg::ADDR_OPCODE: rdata = {29'h0, st.disc};
      xcp_pkg::ADDR_DATA: rdata = {24'h0, st.chr};
      xcp_pkg::ADDR_STATUS: rdata = status;
      xcp_pkg::ADDR_INT_STATUS: rdata = {29'h0, st.ist};
      xcp_pkg::ADDR_INT_MASK: rdata = {29'h0, st.mask};
      default: hit = 1'b0;
    endcase
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_st = st;
    next_st.strb_d = strb_s;
    next_st.halt_d = halted;
    next_st.echo = ~strb_s;
    next_st.cbuf = ~strbc_s;
    if (st.hold != '0) begin
      next_st.hold = st.hold - 1'b1;
    end
    if (cap) begin
      next_st.chr = data_s;
      next_st.full = 1'b1;
      next_st.sreq = 1'b0;
      next_st.perr = par_err & ~inh_s;
      next_st.hold = gap;
    end else if (act && !st.full && !st.sreq && st.hold == '0) begin
      next_st.sreq = 1'b1;
    end
    if (!act) begin
      next_st.sreq = 1'b0;
    end
    next_st.act = act;
    next_st.inact = ~act;
    next_st.rdy = act & ~next_st.sreq;

    ev = 3'h0;
    ev[xcp_pkg::EV_CHAR_BIT] = cap;
    ev[xcp_pkg::EV_PERR_BIT] = cap & par_err & ~inh_s;
    ev[xcp_pkg::EV_HALT_BIT] = halted & ~st.halt_d;
    // a new event wins over the read clear
    next_st.ist = (st.ist & ~clr) | ev;

    next_st.pready = setup;
    next_st.pslverr = setup & ~hit;
    next_st.prdata = setup ? rdata : 32'h0;

    // a capture in the same cycle as the data read keeps the new character pending
    if (rd && paddr == xcp_pkg::ADDR_DATA && !cap) begin
      next_st.full = 1'b0;
    end
    if (wr) begin
      case (paddr)
        xcp_pkg::ADDR_CTRL: begin
          next_st.ext_en = pwdata[xcp_pkg::CTRL_EXT_EN_BIT];
          next_st.rate = pwdata[xcp_pkg::CTRL_RATE_LSB +: 2];
        end
        xcp_pkg::ADDR_OPCODE: begin
          case (pwdata[11:0])
            xcp_pkg::OP_DISC4: next_st.disc = 3'h1;
            xcp_pkg::OP_DISC5: next_st.disc = 3'h2;
            xcp_pkg::OP_DISC6: next_st.disc = 3'h4;
            xcp_pkg::OP_DISC_OFF: next_st.disc = 3'h0;
            default: next_st.disc = st.disc;
          endcase
        end
        xcp_pkg::ADDR_INT_MASK: next_st.mask = pwdata[2:0];
        default: next_st.mask = st.mask;
      endcase
    end
    next_st.irq = |(next_st.ist & next_st.mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.ext_en <= xcp_pkg::CTRL_EXT_EN_RST;
      st.rate <= xcp_pkg::CTRL_RATE_RST;
      st.mask <= xcp_pkg::INT_MASK_RST;
      st.echo <= 1'b1;
      st.cbuf <= 1'b1;
      st.inact <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign irq = st.irq;
  assign strobe_echo_out = st.echo;
  assign strobe_complement_buffered_out = st.cbuf;
  assign sample_request_out = st.sreq;
  assign ext_input_active = st.act;
  assign ext_input_inactive = st.inact;
  assign input_ready_out = st.rdy;
  assign parity_error_out = st.perr;
  assign {discrete_out_6, discrete_out_5, discrete_out_4} = st.disc;

  // ****************************************
  // assertions
  // ****************************************
  a_echo_inverse: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 strobe_echo_out == !$past(strb_s)) else $error("strobe echo not inverse");
  a_cbuf_inverse: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 strobe_complement_buffered_out == !$past(strbc_s)) else $error("buffered strobe wrong");
  a_sreq_drop: assert property (@(posedge pclk) disable iff (!presetn)
    sample_request_out && rise |=> !sample_request_out) else $error("sample request held");
  a_inact_inverse: assert property (@(posedge pclk) disable iff (!presetn)
    ext_input_inactive != ext_input_active) else $error("inactive not inverse");
  a_ready_gate: assert property (@(posedge pclk) disable iff (!presetn)
    input_ready_out |-> ext_input_active && !sample_request_out) else $error("ready ungated");
  a_halt_blocks: assert property (@(posedge pclk) disable iff (!presetn)
    halted |=> !ext_input_active ##0 !sample_request_out) else $error("active while halted");
  a_inhibit_par: assert property (@(posedge pclk) disable iff (!presetn)
    cap && inh_s |=> !parity_error_out) else $error("parity flagged while inhibited");
  a_par_flag: assert property (@(posedge pclk) disable iff (!presetn)
    cap && !inh_s && (psel_s == !(^data_s)) |=> parity_error_out) else $error("parity missed");
  a_disc_onehot: assert property (@(posedge pclk) disable iff (!presetn)
    $onehot0({discrete_out_6, discrete_out_5, discrete_out_4})) else $error("two discretes");
  a_disc_code: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == xcp_pkg::ADDR_OPCODE && pwdata[11:0] == xcp_pkg::OP_DISC5
    |=> discrete_out_5 && !discrete_out_4 && !discrete_out_6) else $error("code 3712 missed");
  a_capture_data: assert property (@(posedge pclk) disable iff (!presetn)
    cap |=> st.chr == $past(data_s) && st.full) else $error("character not captured");
  a_rate_gap: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(sample_request_out) |-> $past(st.hold) == '0) else $error("rate gap violated");

endmodule

// ===== xcp_parity.sv
`timescale 1ns/1ps
module xcp_parity #(
  parameter int W = 8
) (
  input wire logic [W-1:0] data,
  input wire logic odd_sel,
  output logic err
);

  // odd check fails on even count of ones, even check on odd count
  assign err = odd_sel ? ~(^data) : (^data);

endmodule

// ===== xcp_pkg.sv
package xcp_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_NS = 4;
  localparam int NS_PER_S = 1000000000;
  localparam int AN6_CPS = 4000;
  localparam int AN5_CPS = 3500;
  localparam int OCT_CPS = 500;
  // least spacing between characters, rounded up
  localparam int AN6_GAP_NS = (NS_PER_S + AN6_CPS - 1) / AN6_CPS;
  localparam int AN5_GAP_NS = (NS_PER_S + AN5_CPS - 1) / AN5_CPS;
  localparam int OCT_GAP_NS = (NS_PER_S + OCT_CPS - 1) / OCT_CPS;
  localparam int AN6_GAP_CYC = (AN6_GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int AN5_GAP_CYC = (AN5_GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int OCT_GAP_CYC = (OCT_GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int GAP_W = 20;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_OPCODE = 8'h04;
  localparam logic [7:0] ADDR_DATA = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_INT_STATUS = 8'h10;
  localparam logic [7:0] ADDR_INT_MASK = 8'h14;

  // ctrl fields
  localparam int CTRL_EXT_EN_BIT = 0;
  localparam int CTRL_RATE_LSB = 1;
  localparam logic CTRL_EXT_EN_RST = 1'b0;
  localparam logic [1:0] CTRL_RATE_RST = 2'h0;

  // character rate modes
  localparam logic [1:0] RATE_AN6 = 2'h0;
  localparam logic [1:0] RATE_AN5 = 2'h1;
  localparam logic [1:0] RATE_OCT = 2'h2;

  // status fields
  localparam int ST_ACTIVE_BIT = 0;
  localparam int ST_HALTED_BIT = 1;
  localparam int ST_VERIFY_BIT = 2;
  localparam int ST_FULL_BIT = 3;
  localparam int ST_SREQ_BIT = 4;
  localparam int ST_PERR_BIT = 5;
  localparam int ST_DISC_LSB = 6;

  // interrupt events
  localparam int EV_W = 3;
  localparam int EV_CHAR_BIT = 0;
  localparam int EV_PERR_BIT = 1;
  localparam int EV_HALT_BIT = 2;
  localparam logic [2:0] INT_MASK_RST = 3'h0;

  // operation codes (octal 3710, 3712, 3714, 3700)
  localparam logic [11:0] OP_DISC4 = 12'h7C8;
  localparam logic [11:0] OP_DISC5 = 12'h7CA;
  localparam logic [11:0] OP_DISC6 = 12'h7CC;
  localparam logic [11:0] OP_DISC_OFF = 12'h7C0;

  localparam int SYNC_W = 15;

endpackage

// ===== xcp_sync.sv
`timescale 1ns/1ps
module xcp_sync #(
  parameter int W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] meta;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule

// ===== xcp_tape_model.sv
`timescale 1ns/1ps
module xcp_tape_model (
  input wire logic pclk,
  input wire logic send,
  input wire logic slow,
  input wire logic rogue,
  input wire logic [7:0] chr,
  input wire logic sample_request_out,
  input wire logic strobe_echo_out,
  output logic [7:0] data,
  output logic input_strobe,
  output logic input_strobe_complement
);
  assign input_strobe_complement = ~input_strobe;
  initial begin
    data = 8'h5A;
    input_strobe = 1'b0;
    forever begin
      @(posedge pclk);
      // rogue strobes ignore the request on purpose
      if (send && (sample_request_out || rogue)) begin
        data <= chr;
        repeat (slow ? 8 : 2) @(posedge pclk);
        input_strobe <= 1'b1;
        for (int i = 0; i < 40 && strobe_echo_out; i++) begin
          @(posedge pclk);
        end
        input_strobe <= 1'b0;
        // released lines do not keep the character
        data <= ~chr;
      end
    end
  end
endmodule
